// >>> hdl/srp_device.sv
// Converter end: conversion timing, abort reset, trim init and lane mux.
// Assumes analog result arrives as sample_code; pins synchronised here.
`timescale 1ns/100ps
module srp_device (
	// Clock and reset
	input  wire logic         core_clk,
	input  wire logic         sys_rst,
	// Pin side
	srp_if.dev                pins,
	// Analog front end
	input  wire logic [17:0]  sample_code,
	output logic              acquiring,
	output logic              trim_done,
	output logic              result_valid
);
	import srp_pkg::*;

	logic [1:0] cs_s_ff, rd_s_ff, cv_s_ff, by_s_ff, nb_s_ff;
	logic       cs_d_ff, cv_d_ff, rd_d_ff;
	logic       busy_ff;
	logic [7:0] conv_cnt_ff;
	logic [17:0] latch_ff;
	logic [1:0] init_cnt_ff;
	logic [1:0] bad_cnt_ff;
	logic       acq_ff;
	logic       trim_ff;
	logic       valid_ff;
	logic [17:0] nxt_pins;
	logic       cs_fall, cv_fall, rd_rise, abort;
	logic [17:0] out_ff;
	logic       oe_ff;

	// Two-flop synchronisers for all pin inputs
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			cs_s_ff <= 2'h3;
			rd_s_ff <= 2'h3;
			cv_s_ff <= 2'h3;
			by_s_ff <= 2'h0;
			nb_s_ff <= 2'h0;
		end
		else
		begin
			cs_s_ff <= {cs_s_ff[0], pins.chip_select_n};
			rd_s_ff <= {rd_s_ff[0], pins.read_n};
			cv_s_ff <= {cv_s_ff[0], pins.conversion_start_n};
			by_s_ff <= {by_s_ff[0], pins.byte_shift};
			nb_s_ff <= {nb_s_ff[0], pins.narrow_bus_select};
		end
	end

	// Delayed copies for edge detection
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			cs_d_ff <= 1'b1;
			cv_d_ff <= 1'b1;
			rd_d_ff <= 1'b1;
		end
		else
		begin
			cs_d_ff <= cs_s_ff[1];
			cv_d_ff <= cv_s_ff[1];
			rd_d_ff <= rd_s_ff[1];
		end
	end

	assign cs_fall = cs_d_ff & ~cs_s_ff[1];
	assign cv_fall = cv_d_ff & ~cv_s_ff[1];
	assign rd_rise = ~rd_d_ff & rd_s_ff[1];
	// Abort on start fall with select low, or select fall, mid-conversion
	assign abort = busy_ff & ((cv_fall & ~cs_s_ff[1]) | cs_fall);

	// Conversion sequencer and busy
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			busy_ff     <= 1'b0;
			conv_cnt_ff <= 8'h00;
		end
		else if (abort)
		begin
			busy_ff     <= 1'b0;
			conv_cnt_ff <= 8'h00;
		end
		else if (!busy_ff && cv_fall && !cs_s_ff[1])
		begin
			busy_ff     <= 1'b1;
			conv_cnt_ff <= 8'(CONV_CYC - 1);
		end
		else if (busy_ff)
		begin
			if (conv_cnt_ff == 8'h00)
				busy_ff <= 1'b0;
			else
				conv_cnt_ff <= conv_cnt_ff - 8'h01;
		end
	end

	// Output latch: cleared on abort, loaded at conversion end
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
			latch_ff <= RESULT_RST;
		else if (abort)
			latch_ff <= RESULT_RST;
		else if (busy_ff && conv_cnt_ff == 8'h00)
			latch_ff <= sample_code;
	end

	// Acquisition phase tracking
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
			acq_ff <= 1'b0;
		else if (busy_ff && !abort && conv_cnt_ff == 8'h00 && !cs_s_ff[1])
			acq_ff <= 1'b1;
		else if (abort)
			acq_ff <= 1'b1;
		else if (cv_fall && !cs_s_ff[1])
			acq_ff <= 1'b0; // Taken start ends sampling, even with select fall
		else if (!busy_ff && cs_fall)
			acq_ff <= 1'b1;
	end

	// Trim load counts read cycles after power-up
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			init_cnt_ff <= 2'h0;
			trim_ff     <= 1'b0;
		end
		else if (!trim_ff && rd_rise)
		begin
			init_cnt_ff <= init_cnt_ff + 2'h1;
			if (init_cnt_ff == 2'(INIT_READS - 1))
				trim_ff <= 1'b1;
		end
	end

	// The first three conversions before trim give invalid results
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			bad_cnt_ff <= 2'h0;
			valid_ff   <= 1'b0;
		end
		else if (busy_ff && !abort && conv_cnt_ff == 8'h00)
		begin
			if (!trim_ff && bad_cnt_ff != 2'(BAD_CONVS))
				bad_cnt_ff <= bad_cnt_ff + 2'h1;
			valid_ff <= trim_ff || bad_cnt_ff == 2'(BAD_CONVS);
		end
		else if (abort)
			valid_ff <= 1'b0;
	end

	// Lane multiplexer, follows selects directly
	always_comb
	begin
		nxt_pins = '1;
		case ({by_s_ff[1], nb_s_ff[1]})
			2'b00: nxt_pins = latch_ff;
			2'b01: nxt_pins[LANE_LO2_LSB +: 2] = latch_ff[1:0];
			2'b10: nxt_pins[LANE_HI_LSB +: 8] = latch_ff[9:2];
			2'b11: nxt_pins[LANE_HI_LSB +: 2] = latch_ff[1:0];
			default: nxt_pins = '1;
		endcase
	end

	// Registered pin drivers, updated every cycle
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			out_ff <= RESULT_RST;
			oe_ff  <= 1'b0;
		end
		else
		begin
			out_ff <= nxt_pins;
			oe_ff  <= ~cs_s_ff[1] & ~rd_s_ff[1];
		end
	end

	assign pins.result_out = out_ff;
	assign pins.result_oe  = oe_ff;
	assign pins.busy       = busy_ff;
	assign acquiring       = acq_ff;
	assign trim_done       = trim_ff;
	assign result_valid    = valid_ff;

endmodule : srp_device

// >>> hdl/srp_pkg.sv
// Shared constants and types for the parallel result readout link.
// Assumes a single 100 MHz core_clk shared by both ends.
package srp_pkg;

	localparam int RESULT_W = 18;

	// Ideal output codes
	localparam logic [17:0] CODE_ZERO      = 18'h0_0000;
	localparam logic [17:0] CODE_MID       = 18'h2_0000;
	localparam logic [17:0] CODE_MID_M1    = 18'h1_FFFF;
	localparam logic [17:0] CODE_FULL      = 18'h3_FFFF;
	localparam logic [17:0] RESULT_RST     = 18'h0_0000;

	// Timing
	localparam int CLK_PERIOD_NS   = 10;
	localparam int START_LOW_NS    = 40;
	localparam int START_LOW_CYC   = (START_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CONV_CYC        = 64;
	localparam int INIT_READS      = 3;
	localparam int BAD_CONVS       = 3;
	localparam int RD_LOW_CYC      = 2;

	// Lane positions
	localparam int LANE_HI_LSB     = 10;
	localparam int LANE_LO2_LSB    = 2;

	typedef enum logic [3:0] {
		HS_IDLE  = 4'b0001,
		HS_START = 4'b0010,
		HS_WAIT  = 4'b0100,
		HS_READ  = 4'b1000
	} srp_hstate_t;

	// Read width requested by host user
	typedef enum logic [1:0] {
		RW_18 = 2'b00,
		RW_16 = 2'b01,
		RW_8  = 2'b10,
		RW_8S = 2'b11
	} srp_rwidth_t;

endpackage : srp_pkg

// >>> hdl/srp_if.sv
// Pin-level link between the converter readout and its host.
// Assumes the testbench resolves result_in from the output enable.
`timescale 1ns/100ps
interface srp_if;
	logic        chip_select_n;
	logic        read_n;
	logic        conversion_start_n;
	logic        byte_shift;
	logic        narrow_bus_select;
	logic        busy;
	logic [17:0] result_out;
	logic        result_oe;
	logic [17:0] result_in;

	modport dev  (input chip_select_n, read_n, conversion_start_n, byte_shift,
		narrow_bus_select, output busy, result_out, result_oe);
	modport host (output chip_select_n, read_n, conversion_start_n, byte_shift,
		narrow_bus_select, input busy, result_in);
endinterface : srp_if

// >>> hdl/srp_host.sv
// Host end: init reads, conversion start and multiword result reads.
// Assumes the device end shares core_clk; busy and data are synchronised.
`timescale 1ns/100ps
module srp_host (
	// Clock and reset
	input  wire logic         core_clk,
	input  wire logic         sys_rst,
	// Pin side
	srp_if.host               pins,
	// User side
	input  wire logic         conv_req,
	input  wire srp_pkg::srp_rwidth_t read_width,
	output logic              ready,
	output logic [17:0]       result,
	output logic              result_strobe
);
	import srp_pkg::*;

	srp_hstate_t state_ff;
	logic [1:0]  bsy_s_ff;
	logic [17:0] din_s1_ff, din_s2_ff;
	logic [3:0]  tmr_ff;
	logic [1:0]  word_ff;
	logic [1:0]  init_ff;
	logic        init_done_ff;
	logic        rd_ff, cs_ff, cv_ff, by_ff, nb_ff;
	logic [17:0] acc_ff;
	logic [17:0] res_ff;
	logic        stb_ff;
	logic        rdy_ff;
	srp_rwidth_t wid_ff;
	logic [1:0]  last_word;
	logic [17:0] nxt_acc;

	// Synchronise busy and data
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			bsy_s_ff  <= 2'h0;
			din_s1_ff <= 18'h0_0000;
			din_s2_ff <= 18'h0_0000;
		end
		else
		begin
			bsy_s_ff  <= {bsy_s_ff[0], pins.busy};
			din_s1_ff <= pins.result_in;
			din_s2_ff <= din_s1_ff;
		end
	end

	// Index of the last word; short byte mode still reads two words
	assign last_word = (wid_ff == RW_18) ? 2'h0 :
		(wid_ff == RW_8) ? 2'h2 : 2'h1;

	// Accumulator with the word now on the bus merged in
	always_comb
	begin
		nxt_acc = acc_ff;
		case (wid_ff)
			RW_16:
			begin
				if (word_ff == 2'h0)
					nxt_acc[17:2] = din_s2_ff[17:2];
				else
					nxt_acc[1:0] = din_s2_ff[3:2];
			end
			RW_8, RW_8S:
			begin
				if (word_ff == 2'h0)
					nxt_acc[17:10] = din_s2_ff[17:10];
				else if (word_ff == 2'h1)
					nxt_acc[9:2] = din_s2_ff[17:10];
				else
					nxt_acc[1:0] = din_s2_ff[11:10];
			end
			default: nxt_acc = din_s2_ff;
		endcase
	end

	// Sequencer: init reads, start, wait, word reads
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			state_ff <= HS_IDLE;
			tmr_ff <= 4'h0; word_ff <= 2'h0; init_ff <= 2'h0;
			init_done_ff <= 1'b0;
			rd_ff <= 1'b1; cs_ff <= 1'b1; cv_ff <= 1'b1; by_ff <= 1'b0; nb_ff <= 1'b0;
			acc_ff <= 18'h0_0000; res_ff <= 18'h0_0000; stb_ff <= 1'b0;
			rdy_ff <= 1'b0; wid_ff <= RW_18;
		end
		else
		begin
			stb_ff <= 1'b0;
			case (state_ff)
				HS_IDLE:
				begin
					if (!init_done_ff)
					begin
						// Toggle read three times before any conversion
						cs_ff <= 1'b0;
						tmr_ff <= tmr_ff + 4'h1;
						if (tmr_ff == 4'(RD_LOW_CYC * 2 + 1))
							tmr_ff <= 4'h0;
						rd_ff <= tmr_ff >= 4'(RD_LOW_CYC);
						if (tmr_ff == 4'(RD_LOW_CYC * 2 + 1))
						begin
							init_ff <= init_ff + 2'h1;
							if (init_ff == 2'(INIT_READS - 1))
							begin
								init_done_ff <= 1'b1;
								rdy_ff <= 1'b1;
								cs_ff <= 1'b1;
							end
						end
					end
					else if (conv_req)
					begin
						wid_ff <= read_width;
						rdy_ff <= 1'b0;
						cs_ff  <= 1'b0;
						cv_ff  <= 1'b0;
						tmr_ff <= 4'h0;
						state_ff <= HS_START;
					end
				end
				HS_START:
				begin
					// Hold start low at least 40 ns
					tmr_ff <= tmr_ff + 4'h1;
					if (tmr_ff == 4'(START_LOW_CYC + 3))
					begin
						cv_ff <= 1'b1;
						state_ff <= HS_WAIT;
					end
				end
				HS_WAIT:
				begin
					if (!bsy_s_ff[1])
					begin
						rd_ff <= 1'b0;
						by_ff <= 1'b0; nb_ff <= 1'b0;
						word_ff <= 2'h0; tmr_ff <= 4'h0;
						state_ff <= HS_READ;
					end
				end
				HS_READ:
				begin
					// Read held low; lanes stepped, each word sampled 6 cycles after its select
					tmr_ff <= tmr_ff + 4'h1;
					if (tmr_ff == 4'h5)
					begin
						tmr_ff <= 4'h0;
						acc_ff <= nxt_acc;
						word_ff <= word_ff + 2'h1;
						// Next lane selection, changed with read held low
						by_ff <= (wid_ff == RW_8 || wid_ff == RW_8S);
						nb_ff <= (wid_ff == RW_16) || (word_ff == 2'h1);
						if (word_ff == last_word)
						begin
							// Short byte mode stops after two reads
							state_ff <= HS_IDLE;
							rd_ff <= 1'b1; cs_ff <= 1'b1;
							by_ff <= 1'b0; nb_ff <= 1'b0;
							stb_ff <= 1'b1; rdy_ff <= 1'b1;
							res_ff <= nxt_acc; // Last word included
						end
					end
				end
				default: state_ff <= HS_IDLE;
			endcase
		end
	end

	assign pins.chip_select_n      = cs_ff;
	assign pins.read_n             = rd_ff;
	assign pins.conversion_start_n = cv_ff;
	assign pins.byte_shift         = by_ff;
	assign pins.narrow_bus_select  = nb_ff;
	assign ready                   = rdy_ff;
	assign result                  = res_ff;
	assign result_strobe           = stb_ff;

endmodule : srp_host

// >>> tb/srp_assertions.sv
// Assertions on the pin link between the host and converter ends.
// Assumes one core_clk; inputs are the link signals as plain wires.
`timescale 1ns/100ps
module srp_assertions (
	// Clock and reset
	input wire logic        core_clk,
	input wire logic        sys_rst,
	// Link pins
	input wire logic        chip_select_n,
	input wire logic        read_n,
	input wire logic        conversion_start_n,
	input wire logic        byte_shift,
	input wire logic        narrow_bus_select,
	input wire logic        busy,
	input wire logic [17:0] result_out,
	input wire logic        result_oe
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	logic rd_on;
	// Read window seen at the pins
	assign rd_on = !chip_select_n && !read_n;
	// Bus drive follows select and read
	sel_drive_a: assert property (rd_on[*5] |-> result_oe)
		else $error("bus not driven during read");
	bus_release_a: assert property ((!rd_on)[*5] |-> !result_oe)
		else $error("bus driven outside read");
	// Unused lanes read as ones
	narrow_ones_a: assert property ((rd_on && narrow_bus_select && !byte_shift)[*5]
		|-> result_out[17:4] == 14'h3FFF && result_out[1:0] == 2'b11)
		else $error("narrow lane pattern wrong");
	shift_ones_a: assert property ((rd_on && byte_shift && !narrow_bus_select)[*5]
		|-> result_out[9:0] == 10'h3FF)
		else $error("shifted lane pattern wrong");
	both_ones_a: assert property ((rd_on && byte_shift && narrow_bus_select)[*5]
		|-> {result_out[17:12], result_out[9:0]} == 16'hFFFF)
		else $error("last byte lane pattern wrong");
	// Conversion start and length
	busy_start_a: assert property ($fell(conversion_start_n) && !chip_select_n && !busy
		|-> ##[1:4] busy)
		else $error("busy did not rise after start");
	busy_cause_a: assert property ($rose(busy) |-> $past(!conversion_start_n, 3))
		else $error("busy rose without start");
	busy_length_a: assert property ($rose(busy) |-> ##63 busy ##1 !busy)
		else $error("conversion length wrong");
	abort_clear_a: assert property (busy && $fell(chip_select_n) |-> ##[1:4] !busy)
		else $error("select fall did not abort");
	cover property ($rose(busy));
	cover property ((rd_on && byte_shift && narrow_bus_select)[*5]);
	cover property ((rd_on && narrow_bus_select && !byte_shift)[*5]);
endmodule : srp_assertions

// >>> tb/tb.sv
// Bench: host and converter ends face each other; a second converter end
// is driven directly by the bench. Assumes core_clk at 100 MHz.
`timescale 1ns/100ps
module tb;
	import srp_pkg::*;
	logic        core_clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic        conv_req = 1'b0;
	srp_rwidth_t read_width = RW_18;
	logic [17:0] sample_code = CODE_ZERO;
	logic [17:0] probe_code = CODE_ZERO;
	logic        ready;
	logic        result_strobe;
	logic [17:0] result;
	logic        acquiring;
	logic        trim_done;
	logic        result_valid;
	logic        probe_acq;
	logic [17:0] exp_q[$];
	logic [17:0] msk_q[$];
	logic [17:0] code_tab[5];
	int          fail_count = 0;
	int          n_checks = 0;
	srp_if link ();
	srp_if probe ();
	// Released bus shows the inverse of the last word
	assign link.result_in = link.result_oe ? link.result_out : ~link.result_out;
	assign probe.result_in = probe.result_oe ? probe.result_out : ~probe.result_out;
	always #5 core_clk = ~core_clk;
	srp_device srp_device_i (.core_clk(core_clk), .sys_rst(sys_rst), .pins(link),
		.sample_code(sample_code), .acquiring(acquiring), .trim_done(trim_done),
		.result_valid(result_valid));
	srp_host srp_host_i (.core_clk(core_clk), .sys_rst(sys_rst), .pins(link),
		.conv_req(conv_req), .read_width(read_width), .ready(ready),
		.result(result), .result_strobe(result_strobe));
	srp_device srp_device_b_i (.core_clk(core_clk), .sys_rst(sys_rst), .pins(probe),
		.sample_code(probe_code), .acquiring(probe_acq), .trim_done(),
		.result_valid());
	srp_assertions srp_assertions_i (.core_clk(core_clk), .sys_rst(sys_rst),
		.chip_select_n(link.chip_select_n), .read_n(link.read_n),
		.conversion_start_n(link.conversion_start_n), .byte_shift(link.byte_shift),
		.narrow_bus_select(link.narrow_bus_select), .busy(link.busy),
		.result_out(link.result_out), .result_oe(link.result_oe));

	task automatic check(input string what, input logic [17:0] seen, input logic [17:0] expd);
		n_checks++;
		if (seen !== expd)
		begin
			fail_count++;
			$display("unexpected %s expected %h seen %h", what, expd, seen);
		end
	endtask : check

	task automatic ticks(input int n);
		repeat (n) @(negedge core_clk);
	endtask : ticks

	task automatic complete_run();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : complete_run

	task automatic wait_ready();
		for (int k = 0; k < 400 && ready !== 1'b1; k++)
			ticks(1);
		check("ready", ready, 1'b1);
	endtask : wait_ready

	// One conversion through the host; note the masked expected word
	task automatic convert(input logic [17:0] c, input srp_rwidth_t w);
		logic [17:0] m;
		m = (w == RW_8S) ? 18'h3_FFFC : 18'h3_FFFF;
		wait_ready();
		sample_code = c;
		read_width = w;
		exp_q.push_back(c & m);
		msk_q.push_back(m);
		conv_req = 1'b1;
		ticks(1);
		conv_req = 1'b0;
	endtask : convert

	// Start a conversion on the directly driven end
	task automatic pstart();
		probe.chip_select_n = 1'b0;
		probe.conversion_start_n = 1'b0;
		ticks(5);
		probe.conversion_start_n = 1'b1;
		check("busy rise", probe.busy, 1'b1);
	endtask : pstart

	function automatic logic [17:0] lane(input logic [17:0] c, input logic [1:0] sel);
		case (sel)
			2'b00: lane = c;
			2'b01: lane = {14'h3FFF, c[1:0], 2'b11};
			2'b10: lane = {c[9:2], 10'h3FF};
			default: lane = {6'h3F, c[1:0], 10'h3FF};
		endcase
	endfunction : lane

	// Compare each delivered word with the oldest note
	always @(negedge core_clk)
	begin
		if (result_strobe === 1'b1 && exp_q.size() > 0)
		begin
			check("result", result & msk_q[0], exp_q[0]);
			void'(exp_q.pop_front());
			void'(msk_q.pop_front());
		end
		else if (result_strobe === 1'b1)
			check("extra result", 18'h0_0001, 18'h0_0000);
	end

	// Cut a hang short
	initial
	begin
		#300000;
		fail_count++;
		complete_run();
	end

	// Main sequence
	initial
	begin
		{probe.chip_select_n, probe.read_n, probe.conversion_start_n} = 3'b111;
		{probe.byte_shift, probe.narrow_bus_select} = 2'b00;
		void'($urandom(32'h95c7));
		ticks(2);
		sys_rst = 1'b0;
		wait_ready();
		check("trim done", trim_done, 1'b1);
		$display("test init done");
		code_tab = '{CODE_ZERO, CODE_MID, CODE_MID_M1, CODE_FULL, CODE_ZERO};
		for (int w = 0; w < 4; w++)
			for (int c = 0; c < 5; c++)
				convert(c == 4 ? 18'($urandom()) : code_tab[c], srp_rwidth_t'(w));
		wait_ready();
		ticks(2);
		check("pending words", 18'(exp_q.size()), 18'h0_0000);
		check("valid", result_valid, 1'b1);
		$display("test widths done");
		probe_code = 18'($urandom());
		for (int i = 0; i < INIT_READS; i++)
		begin
			probe.read_n = 1'b0;
			ticks(2);
			probe.read_n = 1'b1;
			ticks(4);
		end
		pstart();
		ticks(CONV_CYC + 6);
		check("busy end", probe.busy, 1'b0);
		probe.read_n = 1'b0;
		for (int j = 0; j < 4; j++)
		begin
			{probe.byte_shift, probe.narrow_bus_select} = 2'(j);
			ticks(5);
			check("lane", probe.result_in, lane(probe_code, 2'(j)));
		end
		probe.chip_select_n = 1'b1;
		ticks(5);
		check("bus release", probe.result_oe, 1'b0);
		$display("test lanes done");
		{probe.byte_shift, probe.narrow_bus_select} = 2'b00;
		pstart();
		check("hold", probe_acq, 1'b0);
		ticks(4);
		probe.conversion_start_n = 1'b0;
		ticks(5);
		probe.conversion_start_n = 1'b1;
		check("start abort busy", probe.busy, 1'b0);
		check("start abort latch", probe.result_in, 18'h0_0000);
		check("acquire", probe_acq, 1'b1);
		ticks(4);
		pstart();
		ticks(CONV_CYC + 4);
		check("acquire end", probe_acq, 1'b1);
		check("latch loaded", probe.result_in, probe_code);
		pstart();
		probe.chip_select_n = 1'b1;
		ticks(4);
		probe.chip_select_n = 1'b0;
		ticks(5);
		check("select abort busy", probe.busy, 1'b0);
		check("select abort latch", probe.result_in, 18'h0_0000);
		$display("test abort done");
		complete_run();
	end
endmodule : tb
